// ---- design/zcb_consts.vh ----
`ifndef ZCB_CONSTS_VH
`define ZCB_CONSTS_VH
`define OPC_HI          31
`define OPC_LO          26
`define SRC_HI          25
`define SRC_LO          21
`define SUB_HI          20
`define SUB_LO          16
`define OFF_HI          15
`define OFF_LO          0
`define SIGN_BIT        31
`define OPC_LE_ZERO     6'h06
`define OPC_LE_ZERO_LK  6'h16
`define OPC_REG_IMM     6'h01
`define SUB_LT          5'h00
`define SUB_LT_LK       5'h02
`define SUB_LT_LINK     5'h10
`define SUB_LT_LINK_LK  5'h12
`define SUB_ZERO        5'h00
`define LINK_REG        5'h1f
`define PC_STEP         32'h00000004
`define PC_RESET        32'h00000000
`define WORD_ZERO       32'h00000000
`define EXT_BITS        14
`define OFF_SIGN        15
`define OFF_PAD         2'h0
`endif

// ---- design/zero_branch_stage.v ----
`timescale 1ns/1ps
`include "zcb_consts.vh"
// Holds the decision made at the branch step for use in the delay-slot step
module zero_branch_stage (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Step advance and decision in
    input  wire        step,
    input  wire        is_branch,
    input  wire        take,
    input  wire        likely,
    input  wire [31:0] target,
    // Held decision out
    output reg         pend,
    output reg         pend_take,
    output reg         pend_likely,
    output reg  [31:0] pend_target
);
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pend        <= 1'h0;
            pend_take   <= 1'h0;
            pend_likely <= 1'h0;
            pend_target <= `WORD_ZERO;
        end else if (step) begin
            pend        <= is_branch;
            pend_take   <= take;
            pend_likely <= likely;
            pend_target <= target;
        end
    end
endmodule // zero_branch_stage

// ---- design/zero_compare_branch_unit.v ----
`timescale 1ns/1ps
`include "zcb_consts.vh"
// Overview of operation
// - Less-or-equal branch taken when sign bit set or register is zero.
// - Plain less-or-equal branch: opcode 000110, bits 20..16 zero.
// - Likely less-or-equal branch: bits 20..16 zero, source field 25..21, offset low.
// - Target is delay-slot address plus sign-extended offset shifted left two.
// - Plain forms and link form 10000 always run the delay slot, then redirect if taken.
// - Likely forms squash the delay slot when the condition is false.
// - Evaluate in branch step; redirect or squash during the delay-slot step.
// - Less-than-zero condition is exactly the source sign bit.
// - Register-immediate class: 00000 plain less-than, 00010 likely form.
// - Register-immediate class: 10000 less-than link, 10010 its likely form.
// - Link forms write register 31 with branch address plus eight.
module zero_compare_branch_unit (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Instruction step
    input  wire        step,
    input  wire [31:0] instr,
    input  wire [31:0] instr_pc,
    input  wire [31:0] src_value,
    // Source register select
    output wire [4:0]  source_register_field,
    // Next PC decision
    output reg  [31:0] next_pc,
    output reg         redirect,
    output reg         squash_delay_slot,
    // Link register write
    output reg         link_we,
    output reg  [4:0]  link_addr,
    output reg  [31:0] link_data,
    // Decode flags
    output reg         is_branch
);
    // Branch forms after decode; the codes never leave this block
    localparam [2:0] FORM_NONE           = 3'h0;
    localparam [2:0] FORM_LE             = 3'h1;
    localparam [2:0] FORM_LE_LIKELY      = 3'h2;
    localparam [2:0] FORM_LT             = 3'h3;
    localparam [2:0] FORM_LT_LIKELY      = 3'h4;
    localparam [2:0] FORM_LT_LINK        = 3'h5;
    localparam [2:0] FORM_LT_LINK_LIKELY = 3'h6;

    // Sign bit set or whole word zero
    function le_zero;
        input [31:0] value;
        begin
            le_zero = value[`SIGN_BIT] | (value == `WORD_ZERO);
        end
    endfunction

    // Sign bit alone decides the less-than-zero forms
    function lt_zero;
        input [31:0] value;
        begin
            lt_zero = value[`SIGN_BIT];
        end
    endfunction

    // Sequential successor of an instruction address
    function [31:0] pc_next_word;
        input [31:0] pc;
        begin
            pc_next_word = pc + `PC_STEP;
        end
    endfunction

    // Offset times four, sign-extended from 18 bits, added to the slot address
    function [31:0] branch_target;
        input [31:0] slot;
        input [15:0] offset;
        begin
            branch_target = slot + {{`EXT_BITS{offset[`OFF_SIGN]}}, offset, `OFF_PAD};
        end
    endfunction

    // Opcode and sub-field to branch form; every other encoding is not ours
    function [2:0] decode_form;
        input [5:0] opcode;
        input [4:0] sub_code;
        begin
            decode_form = FORM_NONE;
            case (opcode)
                `OPC_LE_ZERO: begin
                    if (sub_code == `SUB_ZERO)
                        decode_form = FORM_LE;
                end
                `OPC_LE_ZERO_LK: begin
                    if (sub_code == `SUB_ZERO)
                        decode_form = FORM_LE_LIKELY;
                end
                `OPC_REG_IMM: begin
                    case (sub_code)
                        `SUB_LT:         decode_form = FORM_LT;
                        `SUB_LT_LK:      decode_form = FORM_LT_LIKELY;
                        `SUB_LT_LINK:    decode_form = FORM_LT_LINK;
                        `SUB_LT_LINK_LK: decode_form = FORM_LT_LINK_LIKELY;
                        default:         decode_form = FORM_NONE;
                    endcase
                end
                default: decode_form = FORM_NONE;
            endcase
        end
    endfunction

    // Instruction fields
    wire [5:0]  opc     = instr[`OPC_HI:`OPC_LO];
    wire [4:0]  sub     = instr[`SUB_HI:`SUB_LO];
    wire [15:0] off     = instr[`OFF_HI:`OFF_LO];
    wire [2:0]  form    = decode_form(opc, sub);
    wire [31:0] slot_pc = pc_next_word(instr_pc);
    wire [31:0] tgt     = branch_target(slot_pc, off);

    // Decision of this step
    reg         dec_br;
    reg         dec_lk;
    reg         dec_link;
    reg         dec_take;

    // Decision held from the previous step
    wire        pend;
    wire        pend_take;
    wire        pend_likely;
    wire [31:0] pend_target;

    assign source_register_field = instr[`SRC_HI:`SRC_LO];

    always @* begin
        dec_br   = 1'h0;
        dec_lk   = 1'h0;
        dec_link = 1'h0;
        dec_take = 1'h0;
        case (form)
            FORM_LE: begin
                dec_br   = 1'h1;
                dec_take = le_zero(src_value);
            end
            FORM_LE_LIKELY: begin
                dec_br   = 1'h1;
                dec_lk   = 1'h1;
                dec_take = le_zero(src_value);
            end
            FORM_LT: begin
                dec_br   = 1'h1;
                dec_take = lt_zero(src_value);
            end
            FORM_LT_LIKELY: begin
                dec_br   = 1'h1;
                dec_lk   = 1'h1;
                dec_take = lt_zero(src_value);
            end
            FORM_LT_LINK: begin
                dec_br   = 1'h1;
                dec_link = 1'h1;
                dec_take = lt_zero(src_value);
            end
            FORM_LT_LINK_LIKELY: begin
                dec_br   = 1'h1;
                dec_lk   = 1'h1;
                dec_link = 1'h1;
                dec_take = lt_zero(src_value);
            end
            default: begin
                dec_br   = 1'h0;
                dec_take = 1'h0;
            end
        endcase
        // A branch inside a delay slot is unpredictable; treating it as an
        // ordinary instruction keeps the pending decision intact
        if (pend) begin
            dec_br   = 1'h0;
            dec_lk   = 1'h0;
            dec_link = 1'h0;
            dec_take = 1'h0;
        end
    end

    // Decision is captured at the branch step, applied one step later
    zero_branch_stage u_stage (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .step        (step),
        .is_branch   (dec_br),
        .take        (dec_take),
        .likely      (dec_lk),
        .target      (tgt),
        .pend        (pend),
        .pend_take   (pend_take),
        .pend_likely (pend_likely),
        .pend_target (pend_target)
    );

    // Values the output registers take at the next step
    wire        next_redirect = pend & pend_take;
    wire        next_squash   = pend & pend_likely & ~pend_take;
    wire [31:0] next_link     = pc_next_word(slot_pc);
    wire [31:0] next_fetch    = next_redirect ? pend_target : pc_next_word(instr_pc);

    // Decision outputs stand until the next step
    always @(posedge core_clk) begin
        if (!rst_n) begin
            next_pc           <= `PC_RESET;
            redirect          <= 1'h0;
            squash_delay_slot <= 1'h0;
            is_branch         <= 1'h0;
        end else if (step) begin
            is_branch         <= dec_br;
            redirect          <= next_redirect;
            squash_delay_slot <= next_squash;
            next_pc           <= next_fetch;
        end
    end

    // Link write pulses for one cycle and fires for not-taken or squashed
    // branches too: the return address does not depend on the outcome
    always @(posedge core_clk) begin
        if (!rst_n) begin
            link_we   <= 1'h0;
            link_addr <= `LINK_REG;
            link_data <= `WORD_ZERO;
        end else begin
            link_we <= step & dec_link;
            if (step) begin
                link_addr <= `LINK_REG;
                link_data <= next_link;
            end
        end
    end
endmodule // zero_compare_branch_unit

// ---- sim/zcb_checker_sva.sv ----
`timescale 1ns/1ps
module zcb_checker (
    // Clock and reset
    input wire        core_clk,
    input wire        rst_n,
    // Watched ports
    input wire        step,
    input wire [31:0] instr,
    input wire [31:0] instr_pc,
    input wire [31:0] src_value,
    input wire [4:0]  source_register_field,
    input wire [31:0] next_pc,
    input wire        redirect,
    input wire        squash_delay_slot,
    input wire        link_we,
    input wire [4:0]  link_addr,
    input wire [31:0] link_data,
    input wire        is_branch
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A step seen with is_branch low is not a delay slot
    wire lnk = instr[31:26] == 6'h01 && (instr[20:16] | 5'h02) == 5'h12;
    wire ltp = instr[31:26] == 6'h01 && instr[20:16] == 5'h00;
    wire lep = (instr[31:26] == 6'h06 || instr[31:26] == 6'h16) && instr[20:16] == 5'h00;
    wire lkp = (instr[31:26] == 6'h16 && instr[20:16] == 5'h00) ||
               (instr[31:26] == 6'h01 && (instr[20:16] | 5'h10) == 5'h12);
    wire le_hit = src_value[31] || src_value == 32'h0;
    src_field_a: assert property (source_register_field == instr[25:21])
        else $error("source field wrong");
    link_reg_a: assert property (link_addr == 5'h1f)
        else $error("link address wrong");
    link_pulse_a: assert property (link_we |=> !link_we)
        else $error("link write too long");
    link_write_a: assert property (step && !is_branch && lnk |=>
        link_we && link_data == $past(instr_pc) + 32'h8) else $error("link write wrong");
    seq_pc_a: assert property (step |=> redirect || next_pc == $past(instr_pc) + 32'h4)
        else $error("next pc wrong");
    one_of_a: assert property (!(redirect && squash_delay_slot))
        else $error("redirect and squash");
    slot_only_a: assert property (step && !is_branch |=> !redirect && !squash_delay_slot)
        else $error("early redirect");
    lt_cond_a: assert property (step && !is_branch && ltp ##1 step |=>
        redirect == $past(src_value[31], 2)) else $error("sign test wrong");
    le_cond_a: assert property (step && !is_branch && lep ##1 step |=>
        redirect == $past(le_hit, 2)) else $error("zero test wrong");
    likely_squash_a: assert property (step && !is_branch ##1 step |=>
        squash_delay_slot == ($past(lkp, 2) && !redirect)) else $error("squash wrong");
    cover property (redirect);
    cover property (squash_delay_slot);
    cover property (link_we);
endmodule // zcb_checker

bind zero_compare_branch_unit zcb_checker chk_i (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .step                  (step),
    .instr                 (instr),
    .instr_pc              (instr_pc),
    .src_value             (src_value),
    .source_register_field (source_register_field),
    .next_pc               (next_pc),
    .redirect              (redirect),
    .squash_delay_slot     (squash_delay_slot),
    .link_we               (link_we),
    .link_addr             (link_addr),
    .link_data             (link_data),
    .is_branch             (is_branch)
);

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    reg         core_clk = 1'h0, rst_n = 1'h0, step = 1'h0;
    reg  [31:0] instr = 32'h0, instr_pc = 32'h0, src_value = 32'h0, pc = 32'h00001000;
    wire [4:0]  source_register_field, link_addr;
    wire [31:0] next_pc, link_data;
    wire        redirect, squash_delay_slot, link_we, is_branch;
    integer     miscompares = 0, tests_run = 0;
    zero_compare_branch_unit DUT (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .step                  (step),
        .instr                 (instr),
        .instr_pc              (instr_pc),
        .src_value             (src_value),
        .source_register_field (source_register_field),
        .next_pc               (next_pc),
        .redirect              (redirect),
        .squash_delay_slot     (squash_delay_slot),
        .link_we               (link_we),
        .link_addr             (link_addr),
        .link_data             (link_data),
        .is_branch             (is_branch)
    );
    always #12.5 core_clk = ~core_clk;
    task chk(input [31:0] a, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (a !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: %h vs %h", $time, a, e);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Branch step, then a no-op delay slot at once, then judge the outcome
    task go(input [31:0] i, input [31:0] s, input br, input t, input lk, input ln);
        reg [31:0] tgt;
        begin
            tgt = pc + 32'h4 + {{14{i[15]}}, i[15:0], 2'h0};
            @(posedge core_clk) #1 step = 1;
            instr = i;
            instr_pc = pc;
            src_value = s;
            @(posedge core_clk) #1 chk(is_branch, br);
            chk(source_register_field, i[25:21]);
            chk(link_we, ln);
            chk(link_data, pc + 32'h8);
            // Delay slot holds a plain no-op, never a control transfer
            instr = 32'h0;
            instr_pc = pc + 32'h4;
            src_value = ~s;
            @(posedge core_clk) #1 step = 0;
            chk(redirect, t);
            chk(squash_delay_slot, lk & !t);
            chk(next_pc, t ? tgt : pc + 32'h8);
            pc = pc + 32'h100;
        end
    endtask
    task le_forms;
        begin
            go(32'h18600010, 32'h0, 1, 1, 0, 0);
            go(32'h1860fffe, 32'h80000000, 1, 1, 0, 0);
            go(32'h18600010, 32'h1, 1, 0, 0, 0);
            go(32'h18640010, 32'h0, 0, 0, 0, 0);
            go(32'h58600010, 32'h7fffffff, 1, 0, 1, 0);
            go(32'h58600010, 32'h0, 1, 1, 1, 0);
        end
    endtask
    task lt_forms;
        begin
            go(32'h04808000, 32'hffffffff, 1, 1, 0, 0);
            go(32'h04800004, 32'h0, 1, 0, 0, 0);
            go(32'h04820004, 32'h80000000, 1, 1, 1, 0);
            go(32'h04820004, 32'h1, 1, 0, 1, 0);
            go(32'h04810004, 32'h80000000, 0, 0, 0, 0);
        end
    endtask
    task link_forms;
        begin
            // Link forms test register 4, never register 31
            go(32'h04900008, 32'h1, 1, 0, 0, 1);
            go(32'h04920008, 32'h1, 1, 0, 1, 1);
            go(32'h04920008, 32'h80000001, 1, 1, 1, 1);
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1;
        chk(link_addr, 5'h1f);
        le_forms;
        lt_forms;
        link_forms;
        final_report;
    end
    initial begin
        #20000 miscompares = miscompares + 1;
        final_report;
    end
endmodule // tb_top
